// ---- rtl/flash_wp_consts.svh ----
// Constants of the flash write-protection block: opcodes, fields, timing
`ifndef FLASH_WP_CONSTS_SVH
`define FLASH_WP_CONSTS_SVH

// Command opcodes
`define OPC_WREN         8'h06
`define OPC_WREN_VOL     8'h50
`define OPC_WRDI         8'h04
`define OPC_WRSR1        8'h01
`define OPC_WRSR2        8'h31
`define OPC_PAGE         8'h02
`define OPC_PAGE_QUAD    8'h32
`define OPC_SECTOR       8'h20
`define OPC_BLOCK32      8'h52
`define OPC_BLOCK64      8'hd8
`define OPC_CHIP_A       8'hc7
`define OPC_CHIP_B       8'h60
`define OPC_RESET_ARM    8'h66
`define OPC_RESET        8'h99
`define OPC_RELEASE      8'hab

// Status register field positions
`define SR1_BUSY         0
`define SR1_WEL          1
`define SR1_GUARD0       7
`define SR2_GUARD1       0
`define SR2_QE           1
`define SR2_LB_LO        3
`define SR2_LB_HI        5
`define SR2_INVERT       6
`define SR1_WR_MASK      8'hfc
`define SR2_WR_MASK      8'h43

// Array geometry and erase spans
`define ADDR_BITS        21
`define SPAN_PAGE        21'h0000ff
`define SPAN_SECTOR      21'h000fff
`define SPAN_BLOCK32     21'h007fff
`define SPAN_BLOCK64     21'h00ffff
`define SPAN_CHIP        21'h1fffff
`define BLOCK_EXP_BASE   5'd15
`define SECTOR_EXP_BASE  5'd11

// Power-up command delay
`define POWERUP_DELAY_US 10
`define CLK_MHZ          125
`define POWERUP_CYCLES   (`POWERUP_DELAY_US * `CLK_MHZ)

`endif

// ---- rtl/flash_wp_pkg.sv ----
// Types shared by the flash write-protection block
`default_nettype none

package flash_wp_pkg;

  // Array operations handed to the program/erase engine
  typedef enum logic [2:0] {
    OP_NONE, OP_PAGE, OP_SECTOR, OP_BLOCK32, OP_BLOCK64, OP_CHIP,
    OP_SEC_PROG, OP_SEC_ERASE
  } array_op_type;

  // Command-acceptance states of the core
  typedef enum logic [1:0] {
    ST_POWERUP, ST_READY, ST_BUSY, ST_DEEP
  } core_state_type;

endpackage : flash_wp_pkg

`default_nettype wire

// ---- rtl/flash_write_guard.sv ----
// Write-protection core of a serial NOR flash with its SPI capture front
// Notes on behaviour
// - Security lock bits come out of reset as zero; security register 0 is always locked.
// - A nonvolatile status write sets any lock bit alone.
// - Lock bits never clear; locked security register refuses program and erase.
// - Quad enable sits in status two bit 1, resets to zero.
// - Quad enable set turns protect and pause pins into data lines.
// - Write, program or erase ending off a byte boundary is ignored.
// - No command is taken in reset nor during the power-up delay.
// - Write enable latch starts cleared after power-up.
// - Program and erase need the write enable latch set; status write takes it or the 50h enable.
// - Latch clears itself when program, erase or status write finishes.
// - Deep power-down ignores everything except the release command.
// - Guard bits can lock status writes until power-up or software reset.
// - Block mode, top: levels one to five protect 1/32 to 1/2.
// - Block mode, bottom: same sizes counted from address zero.
// - Sector mode, top: 4, 8, 16, 32 KB ending at top.
// - Sector mode, bottom: 4, 8, 16, 32 KB from address zero.
// - Invert bit makes the protected range the complement.
// - Program or erase touching a protected address is ignored.
// - Protect pin gates status writes together with the guard bits.
// - Guard 00 latch only, 01 pin, 10 until power cycle, 11 forever.
// - Software reset turns guard pattern 10 back to 00.
// - Status write goes nonvolatile after 06h, volatile after 50h.
`timescale 1ns/100ps
`default_nettype none
`include "flash_wp_consts.svh"

module flash_write_guard
  import flash_wp_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES   = `POWERUP_CYCLES,
  parameter logic [7:0]  DEEP_ENTER_OPC   = 8'hb9,
  parameter logic [7:0]  SEC_PROG_OPC     = 8'h42,
  parameter logic [7:0]  SEC_ERASE_OPC    = 8'h44
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        SCLK_I,
  input  wire logic        CS_N_I,
  input  wire logic        SI_I,
  input  wire logic        WP_N_I,
  input  wire logic        HOLD_N_I,
  input  wire logic        OP_DONE_I,
  output logic             ARRAY_GO_O,
  output logic [2:0]       ARRAY_OP_O,
  output logic [23:0]      ARRAY_ADDR_O,
  output logic             CMD_REJECT_O,
  output logic [7:0]       STATUS1_O,
  output logic [7:0]       STATUS2_O,
  output logic             READY_O,
  output logic             DEEP_PD_O,
  output logic             QUAD_MODE_O,
  output logic             PAUSE_O
);

  // ****************************************************************
  // Link side: capture of the serial frame on the SPI clock
  // ****************************************************************

  logic       fresh;
  logic [2:0] link_bit_cnt;
  logic [3:0] link_byte_cnt;
  logic [6:0] link_shift;
  logic       link_tog;
  logic [7:0] link_byte [4];
  logic [2:0] cur_bit;
  logic [3:0] cur_byte;
  logic [7:0] cur_val;

  // Marks the first clock edge of a frame; chip select high re-arms it
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Counters restart on the first edge so stale frames leave no trace
  assign cur_bit  = fresh ? 3'h0 : link_bit_cnt;
  assign cur_byte = fresh ? 4'h0 : link_byte_cnt;
  assign cur_val  = {fresh ? 7'h00 : link_shift, SI_I};

  // Shifts bits in, keeps the first four bytes and counts the rest
  always_ff @(posedge SCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      link_bit_cnt  <= 3'h0;
      link_byte_cnt <= 4'h0;
      link_shift    <= 7'h00;
      link_tog      <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        link_byte[i] <= 8'h00;
      end
    end else begin
      link_bit_cnt <= 3'(cur_bit + 3'h1);
      link_shift   <= cur_val[6:0];
      if (fresh) begin
        link_tog <= ~link_tog;   // Frame announcement for the core
      end
      if (cur_bit == 3'h7) begin
        if (cur_byte < 4'h4) begin
          link_byte[cur_byte[1:0]] <= cur_val;
        end
        if (cur_byte != 4'hf) begin
          link_byte_cnt <= 4'(cur_byte + 4'h1);
        end else begin
          link_byte_cnt <= cur_byte;
        end
      end else begin
        link_byte_cnt <= cur_byte;
      end
    end
  end

  // ****************************************************************
  // Core side: synchronisers and frame detection
  // ****************************************************************

  logic cs_meta, cs_sync, cs_last;
  logic tog_meta, tog_sync, tog_seen;
  logic wp_meta, wp_sync;
  logic hold_meta, hold_sync;
  logic frame_end;

  // Two flops on the select, protect and pause pins and on the frame toggle
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_last   <= 1'b1;
      tog_meta  <= 1'b0;
      tog_sync  <= 1'b0;
      wp_meta   <= 1'b1;
      wp_sync   <= 1'b1;
      hold_meta <= 1'b1;
      hold_sync <= 1'b1;
    end else begin
      cs_meta   <= CS_N_I;
      cs_sync   <= cs_meta;
      cs_last   <= cs_sync;
      tog_meta  <= link_tog;
      tog_sync  <= tog_meta;
      wp_meta   <= WP_N_I;
      wp_sync   <= wp_meta;
      hold_meta <= HOLD_N_I;
      hold_sync <= hold_meta;
    end
  end

  // A clocked frame has ended; link data is still since the clock stands
  assign frame_end = cs_sync & ~cs_last & (tog_sync != tog_seen);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tog_seen <= 1'b0;
    end else if (cs_sync & ~cs_last) begin
      tog_seen <= tog_sync;
    end
  end

  // ****************************************************************
  // Protection map decode
  // ****************************************************************

  logic [7:0]  vol_sr1, vol_sr2, nv_sr1, nv_sr2;
  logic [2:0]  lock_bits;
  logic [2:0]  level;
  logic [4:0]  size_exp;
  logic [20:0] size_mask;
  logic [20:0] prot_lo, prot_hi;
  logic        prot_none, base_none, base_all, sec_mode, bottom, invert;

  assign level    = vol_sr1[4:2];
  assign sec_mode = vol_sr1[6];
  assign bottom   = vol_sr1[5];
  assign invert   = vol_sr2[`SR2_INVERT];

  // Turns level, granularity, side and invert into one address interval
  always_comb begin
    base_none = (level == 3'h0);
    base_all  = (level[2] & level[1]);
    if (sec_mode) begin
      size_exp = `SECTOR_EXP_BASE + ((level > 3'h4) ? 5'd4 : {2'b00, level});
    end else begin
      size_exp = `BLOCK_EXP_BASE + {2'b00, level};
    end
    size_mask = 21'((22'h1 << size_exp) - 22'h1);
    prot_none = 1'b0;
    // top blocks, bottom blocks, top sectors, bottom sectors
    if (bottom) begin
      prot_lo = 21'h000000;
      prot_hi = size_mask;
    end else begin
      prot_lo = ~size_mask;
      prot_hi = `SPAN_CHIP;
    end
    if (base_all) begin
      prot_lo = 21'h000000;
      prot_hi = `SPAN_CHIP;
    end
    if (!invert) begin
      prot_none = base_none;
    end else if (base_none) begin
      prot_lo = 21'h000000;
      prot_hi = `SPAN_CHIP;
    end else if (base_all) begin
      prot_none = 1'b1;
    end else if (bottom) begin
      prot_lo = 21'(size_mask + 21'h1);
      prot_hi = `SPAN_CHIP;
    end else begin
      prot_lo = 21'h000000;
      prot_hi = 21'(~size_mask - 21'h1);
    end
  end

  // ****************************************************************
  // Command decision
  // ****************************************************************

  core_state_type state;
  logic [7:0]   cmd;
  logic [23:0]  cmd_addr;
  logic [20:0]  op_span, op_lo, op_hi;
  array_op_type op_kind;
  logic         whole, write_enable_latch, vol_wen, reset_armed, guard_locked, sr_cmd;
  logic         hit, sec_locked, allow_array, allow_sr;
  logic [1:0]   guard;
  logic [1:0]   sec_idx;

  assign cmd      = link_byte[0];
  assign cmd_addr = {link_byte[1], link_byte[2], link_byte[3]};
  assign whole    = (link_bit_cnt == 3'h0) && (link_byte_cnt != 4'h0);
  assign guard    = {vol_sr2[`SR2_GUARD1], vol_sr1[`SR1_GUARD0]};
  assign sec_idx  = cmd_addr[13:12];

  // Classifies the command and checks it against every protection
  always_comb begin
    op_kind = OP_NONE;
    op_span = `SPAN_PAGE;
    sr_cmd  = (cmd == `OPC_WRSR1) || (cmd == `OPC_WRSR2);
    unique case (cmd)
      `OPC_PAGE, `OPC_PAGE_QUAD: op_kind = OP_PAGE;
      `OPC_SECTOR:  begin op_kind = OP_SECTOR;  op_span = `SPAN_SECTOR;  end
      `OPC_BLOCK32: begin op_kind = OP_BLOCK32; op_span = `SPAN_BLOCK32; end
      `OPC_BLOCK64: begin op_kind = OP_BLOCK64; op_span = `SPAN_BLOCK64; end
      `OPC_CHIP_A, `OPC_CHIP_B: begin
        op_kind = OP_CHIP;
        op_span = `SPAN_CHIP;
      end
      SEC_PROG_OPC:  op_kind = OP_SEC_PROG;
      SEC_ERASE_OPC: op_kind = OP_SEC_ERASE;
      default:       op_kind = OP_NONE;
    endcase
    op_lo = cmd_addr[20:0] & ~op_span;
    op_hi = cmd_addr[20:0] | op_span;
    hit = !prot_none && !((op_hi < prot_lo) || (op_lo > prot_hi));
    sec_locked = (sec_idx == 2'h0) || lock_bits[sec_idx - 2'h1];
    allow_array = whole && write_enable_latch && (op_kind != OP_NONE) &&
                  ((op_kind == OP_CHIP) || (link_byte_cnt >= 4'h4));
    if ((op_kind == OP_SEC_PROG) || (op_kind == OP_SEC_ERASE)) begin
      allow_array = allow_array && !sec_locked;
    end else begin
      allow_array = allow_array && !hit;
    end
    // pin gating; guard patterns; pin ignored in quad mode
    unique case (guard)
      2'b00:   guard_locked = 1'b0;
      2'b01:   guard_locked = !wp_sync && !vol_sr2[`SR2_QE];
      default: guard_locked = 1'b1;
    endcase
    allow_sr = sr_cmd && whole && (link_byte_cnt >= 4'h2) &&
               (write_enable_latch || vol_wen) && !guard_locked;
  end

  // ****************************************************************
  // State machine
  // ****************************************************************

  logic [$clog2(POWERUP_CYCLES + 1)-1:0] pu_cnt;

  // power-up delay before any command is heard
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pu_cnt <= '0;
      state  <= ST_POWERUP;
    end else begin
      unique case (state)
        ST_POWERUP: begin
          pu_cnt <= pu_cnt + ($bits(pu_cnt))'(1);
          if (pu_cnt == ($bits(pu_cnt))'(POWERUP_CYCLES - 1)) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          if (frame_end && allow_array) begin
            state <= ST_BUSY;
          end else if (frame_end && whole && cmd == DEEP_ENTER_OPC) begin
            state <= ST_DEEP;
          end
        end
        ST_BUSY: begin
          if (OP_DONE_I) begin
            state <= ST_READY;
          end
        end
        // only the release command leaves deep power-down
        ST_DEEP: begin
          if (frame_end && cmd == `OPC_RELEASE) begin
            state <= ST_READY;
          end
        end
      endcase
    end
  end

  logic take;
  assign take = frame_end && (state == ST_READY);

  // ****************************************************************
  // Write enable latches and software reset arming
  // ****************************************************************

  // cleared at power-up; cleared when work finishes
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      write_enable_latch         <= 1'b0;
      vol_wen     <= 1'b0;
      reset_armed <= 1'b0;
    end else if ((state == ST_BUSY) && OP_DONE_I) begin
      write_enable_latch <= 1'b0;
    end else if (take) begin
      reset_armed <= (cmd == `OPC_RESET_ARM);
      if (cmd == `OPC_WREN) begin
        write_enable_latch <= 1'b1;
      end else if (cmd == `OPC_WREN_VOL) begin
        vol_wen <= 1'b1;
      end else if (cmd == `OPC_WRDI || allow_sr ||
                   (cmd == `OPC_RESET && reset_armed)) begin
        write_enable_latch     <= 1'b0;
        vol_wen <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status bits, volatile and nonvolatile copies
  // ****************************************************************

  logic [7:0] new_sr1, new_sr2;
  assign new_sr1 = (cmd == `OPC_WRSR1) ? link_byte[1] : vol_sr1;
  assign new_sr2 = (cmd == `OPC_WRSR2) ? link_byte[1] :
                   (link_byte_cnt >= 4'h3) ? link_byte[2] : vol_sr2;

  // lock bits reset clear; quad enable resets clear
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      vol_sr1   <= 8'h00;
      vol_sr2   <= 8'h00;
      nv_sr1    <= 8'h00;
      nv_sr2    <= 8'h00;
      lock_bits <= 3'h0;
    end else if (take && allow_sr) begin
      vol_sr1 <= new_sr1 & `SR1_WR_MASK;
      vol_sr2 <= new_sr2 & `SR2_WR_MASK;
      if (!vol_wen) begin
        nv_sr1 <= new_sr1 & `SR1_WR_MASK;
        nv_sr2 <= new_sr2 & `SR2_WR_MASK;
        lock_bits <= lock_bits | new_sr2[`SR2_LB_HI:`SR2_LB_LO];
      end
    end else if (take && cmd == `OPC_RESET && reset_armed) begin
      // software reset ends the lock-down; pattern 10 to 00
      vol_sr1 <= nv_sr1;
      vol_sr2 <= nv_sr2;
      if ({nv_sr2[`SR2_GUARD1], nv_sr1[`SR1_GUARD0]} == 2'b10) begin
        nv_sr1[`SR1_GUARD0]  <= 1'b0;
        nv_sr2[`SR2_GUARD1]  <= 1'b0;
        vol_sr1[`SR1_GUARD0] <= 1'b0;
        vol_sr2[`SR2_GUARD1] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  // Launch pulse and refusal pulse per frame
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ARRAY_GO_O   <= 1'b0;
      ARRAY_OP_O   <= OP_NONE;
      ARRAY_ADDR_O <= 24'h000000;
      CMD_REJECT_O <= 1'b0;
    end else begin
      ARRAY_GO_O   <= take && allow_array;
      CMD_REJECT_O <= frame_end && !(take && (allow_array || allow_sr)) &&
                      ((op_kind != OP_NONE) || sr_cmd);
      if (take && allow_array) begin
        ARRAY_OP_O   <= op_kind;
        ARRAY_ADDR_O <= cmd_addr;
      end
    end
  end

  // Status view and pin function selection
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      STATUS1_O   <= 8'h00;
      STATUS2_O   <= 8'h00;
      READY_O     <= 1'b0;
      DEEP_PD_O   <= 1'b0;
      QUAD_MODE_O <= 1'b0;
      PAUSE_O     <= 1'b0;
    end else begin
      STATUS1_O <= {vol_sr1[7:2], write_enable_latch, state == ST_BUSY};
      STATUS2_O <= {1'b0, vol_sr2[`SR2_INVERT], lock_bits, 1'b0,
                    vol_sr2[1:0]};
      READY_O   <= (state == ST_READY);
      DEEP_PD_O <= (state == ST_DEEP);
      // quad mode turns the pins into data lines
      QUAD_MODE_O <= vol_sr2[`SR2_QE];
      // pause honoured only while quad mode is off
      PAUSE_O     <= !vol_sr2[`SR2_QE] && !hold_sync;
    end
  end

endmodule : flash_write_guard
`default_nettype wire

// ---- verif/flash_write_guard_assertions.sv ----
// Port checker for the flash write guard
`timescale 1ns/100ps
`default_nettype none

module flash_write_guard_assertions
  import flash_wp_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = 16
) (
  input wire logic       CLK_I,
  input wire logic       RSTN_I,
  input wire logic       HOLD_N_I,
  input wire logic       OP_DONE_I,
  input wire logic       ARRAY_GO_O,
  input wire logic       CMD_REJECT_O,
  input wire logic [7:0] STATUS1_O,
  input wire logic [7:0] STATUS2_O,
  input wire logic       READY_O,
  input wire logic       DEEP_PD_O,
  input wire logic       QUAD_MODE_O,
  input wire logic       PAUSE_O
);
  // ********
  // Helpers
  // ********
  logic [15:0] age;

  // Cycles since reset, saturating
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      age <= 16'h0000;
    end else if (age != 16'hffff) begin
      age <= age + 16'h0001;
    end
  end

  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  // ********
  // Assertions
  // ********
  // quiet power-up
  chk_quiet_powerup: assert property (age < POWERUP_CYCLES |->
    !READY_O && !ARRAY_GO_O && STATUS1_O == 8'h00 && STATUS2_O == 8'h00)
    else $error("activity during power-up");
  chk_go_needs_wel: assert property (ARRAY_GO_O |-> STATUS1_O[1])
    else $error("launch without write enable");
  chk_go_pulse: assert property (ARRAY_GO_O |->
    !CMD_REJECT_O ##1 !ARRAY_GO_O)
    else $error("launch pulse malformed");
  chk_deep_quiet: assert property (DEEP_PD_O |-> !ARRAY_GO_O)
    else $error("launch in power-down");
  chk_deep_frozen: assert property (DEEP_PD_O && $past(DEEP_PD_O) |->
    $stable(STATUS1_O[7:1]) && $stable(STATUS2_O))
    else $error("status changed in power-down");
  chk_lock_sticky: assert property (
    ($past(STATUS2_O[5:3]) & ~STATUS2_O[5:3]) == 3'b000)
    else $error("lock bit cleared");
  chk_wel_clears: assert property (STATUS1_O[0] && OP_DONE_I |->
    ##[1:4] !STATUS1_O[1])
    else $error("latch kept after finish");
  chk_quad_no_pause: assert property (QUAD_MODE_O |-> !PAUSE_O)
    else $error("pause in quad mode");
  chk_hold_pauses: assert property (
    (!QUAD_MODE_O && !HOLD_N_I) [*4] |-> PAUSE_O)
    else $error("pause pin ignored");
endmodule : flash_write_guard_assertions

`default_nettype wire

// ---- verif/spi_host_model.sv ----
// SPI host model driving command frames into the flash guard
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  // ********
  // Frame driver
  // ********
  // Idle lines: clock still, select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // bit count as asked, MSB first, gap after frame
  task automatic send(input logic [63:0] d, input int n);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = d[63-i];
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    si_o = ~si_o; // Released line shows no stale bit
    #96;
  endtask : send
endmodule : spi_host_model

`default_nettype wire

// ---- verif/flash_write_guard_tb_top.sv ----
// Bench for the flash write guard with its SPI host model
`timescale 1ns/100ps
`default_nettype none
`include "flash_wp_consts.svh"
`define CHK(g, e) check(64'(g), 64'(e))

bind flash_write_guard flash_write_guard_assertions #(
  .POWERUP_CYCLES(POWERUP_CYCLES)
) u_chk (
  .CLK_I       (CLK_I),
  .RSTN_I      (RSTN_I),
  .HOLD_N_I    (HOLD_N_I),
  .OP_DONE_I   (OP_DONE_I),
  .ARRAY_GO_O  (ARRAY_GO_O),
  .CMD_REJECT_O(CMD_REJECT_O),
  .STATUS1_O   (STATUS1_O),
  .STATUS2_O   (STATUS2_O),
  .READY_O     (READY_O),
  .DEEP_PD_O   (DEEP_PD_O),
  .QUAD_MODE_O (QUAD_MODE_O),
  .PAUSE_O     (PAUSE_O)
);

module flash_write_guard_tb_top;
  import flash_wp_pkg::*;
  localparam int unsigned PUP     = 64;
  localparam logic [7:0]  DEEP_ON = 8'hb9;
  localparam logic [7:0]  SEC_ER  = 8'h44;
  localparam logic [7:0]  SEC_PG  = 8'h42;
  // Rows: status one, status two, opcode, address, launch expected
  localparam logic [48:0] MAP [13] = '{
    {8'h04, 8'h00, 8'h20, 24'h1f0000, 1'b0},
    {8'h04, 8'h00, 8'h20, 24'h1ef000, 1'b1},
    {8'h18, 8'h00, 8'hd8, 24'h000000, 1'b0},
    {8'h14, 8'h00, 8'hd8, 24'h0f0000, 1'b1},
    {8'h24, 8'h00, 8'h52, 24'h008000, 1'b0},
    {8'h44, 8'h00, 8'h52, 24'h1f8000, 1'b0},
    {8'h50, 8'h00, 8'h20, 24'h1f7000, 1'b1},
    {8'h6c, 8'h00, 8'h20, 24'h004000, 1'b1},
    {8'h00, 8'h40, 8'h20, 24'h000000, 1'b0},
    {8'h44, 8'h40, 8'h20, 24'h1ff000, 1'b1},
    {8'h18, 8'h40, 8'hc7, 24'h000000, 1'b1},
    {8'h04, 8'h00, 8'h60, 24'h000000, 1'b0},
    {8'h04, 8'h00, 8'h02, 24'h1fff00, 1'b0}};
  logic        clk, rstn, wp_n, hold_n, done, sclk, cs_n, si;
  logic        go, rej, ready, deep, quad, pause, saw_go, saw_rej;
  logic [2:0]  op;
  logic [23:0] addr;
  logic [7:0]  st1, st2;
  int          failures, total_checks;

  flash_write_guard #(
    .POWERUP_CYCLES(PUP),
    .DEEP_ENTER_OPC(DEEP_ON),
    .SEC_PROG_OPC  (SEC_PG),
    .SEC_ERASE_OPC (SEC_ER)
  ) u_dut (
    .CLK_I(clk), .RSTN_I(rstn), .SCLK_I(sclk), .CS_N_I(cs_n),
    .SI_I(si), .WP_N_I(wp_n), .HOLD_N_I(hold_n), .OP_DONE_I(done),
    .ARRAY_GO_O(go), .ARRAY_OP_O(op), .ARRAY_ADDR_O(addr),
    .CMD_REJECT_O(rej), .STATUS1_O(st1), .STATUS2_O(st2),
    .READY_O(ready), .DEEP_PD_O(deep), .QUAD_MODE_O(quad),
    .PAUSE_O(pause)
  );
  spi_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

  // ********
  // Tasks
  // ********
  always #4 clk = ~clk;

  // Verdict and end of run
  task automatic conclude();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One frame; gathers verdict pulses, then finishes a launch
  task automatic frame(input logic [63:0] d, input int n);
    saw_go = 1'b0;
    saw_rej = 1'b0;
    fork
      u_host.send(d, n);
      repeat (n * 6 + 20) begin
        @(negedge clk);
        saw_go |= go;
        saw_rej |= rej;
      end
    join
    if (saw_go) begin
      tick(2);
      `CHK(st1[1:0], 2'b11);
      done = 1'b1;
      tick(1);
      done = 1'b0;
    end
    tick(4);
  endtask : frame

  // write enable ahead of each write-class command
  task automatic wst(input logic [7:0] c, input logic [15:0] v, input int n);
    frame({`OPC_WREN, 56'h0}, 8);
    frame({c, v, 40'h0}, n);
  endtask : wst

  // ********
  // Sequence
  // ********
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
    done = 1'b0;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    `CHK(ready, 1'b0);
    frame({`OPC_WREN, 56'h0}, 8);
    `CHK({ready, st1, st2}, 17'h10000);
    frame({`OPC_SECTOR, 56'h0}, 32);
    `CHK({saw_go, saw_rej}, 2'b01);
    wst(`OPC_SECTOR, 16'h1ff0, 31);
    `CHK({saw_go, saw_rej, st1[1]}, 3'b011);
    frame({`OPC_SECTOR, 24'h1ff000, 32'h0}, 32);
    `CHK({saw_go, op, addr}, {1'b1, OP_SECTOR, 24'h1ff000});
    `CHK(st1[1], 1'b0);
    // Protection map, status written each row
    foreach (MAP[i]) begin
      wst(`OPC_WRSR1, MAP[i][48:33], 24);
      `CHK({st1[6:2], st2[6]}, {MAP[i][47:43], MAP[i][39]});
      wst(MAP[i][32:25], MAP[i][24:9],
          MAP[i][32:25] inside {`OPC_CHIP_A, `OPC_CHIP_B} ? 8 : 32);
      `CHK(saw_go, MAP[i][0]);
    end
    wst(`OPC_WRSR1, 16'h0000, 24);
    wst(`OPC_PAGE_QUAD, 16'h1fff, 40);
    `CHK({saw_go, op, addr}, {1'b1, OP_PAGE, 24'h1fff00});
    wst(`OPC_WRSR2, 16'h1000, 16);
    `CHK(st2[5:3], 3'b010);
    wst(`OPC_WRSR2, 16'h0000, 16);
    `CHK(st2[5:3], 3'b010);
    wst(SEC_ER, 16'h0020, 32);
    `CHK({saw_go, saw_rej}, 2'b01);
    wst(SEC_PG, 16'h0020, 40);
    `CHK({saw_go, saw_rej}, 2'b01);
    wst(SEC_ER, 16'h0010, 32);
    `CHK({saw_go, op}, {1'b1, OP_SEC_ERASE});
    hold_n = 1'b0;
    tick(6);
    `CHK({quad, pause}, 2'b01);
    hold_n = 1'b1;
    wst(`OPC_WRSR2, 16'h0200, 16);
    hold_n = 1'b0;
    tick(6);
    `CHK({quad, pause}, 2'b10);
    hold_n = 1'b1;
    tick(6);
    wst(`OPC_WRSR2, 16'h0000, 16);
    wst(`OPC_WRSR1, 16'h8000, 24);
    wp_n = 1'b0;
    wst(`OPC_WRSR1, 16'h8400, 24);
    `CHK(st1[7:2], 6'h20);
    wp_n = 1'b1;
    wst(`OPC_WRSR1, 16'h0001, 24);
    `CHK({st1[7], st2[0]}, 2'b01);
    wst(`OPC_WRSR1, 16'h0401, 24);
    `CHK(st1[4:2], 3'b000);
    frame({`OPC_RESET_ARM, 56'h0}, 8);
    frame({`OPC_RESET, 56'h0}, 8);
    `CHK(st2[0], 1'b0);
    frame({`OPC_WRDI, 56'h0}, 8);
    frame({`OPC_WREN_VOL, 56'h0}, 8);
    frame({`OPC_WRSR1, 16'h0400, 40'h0}, 24);
    `CHK(st1[4:2], 3'b001);
    frame({`OPC_RESET_ARM, 56'h0}, 8);
    frame({`OPC_RESET, 56'h0}, 8);
    `CHK(st1[4:2], 3'b000);
    frame({DEEP_ON, 56'h0}, 8);
    `CHK(deep, 1'b1);
    wst(`OPC_SECTOR, 16'h0000, 32);
    `CHK({saw_go, saw_rej, st1[1]}, 3'b010);
    frame({`OPC_RELEASE, 56'h0}, 8);
    `CHK(deep, 1'b0);
    conclude();
  end

  // Watchdog well past the expected run length
  initial begin
    #300000;
    failures++;
    conclude();
  end
endmodule : flash_write_guard_tb_top

`default_nettype wire
